// ---- hw/hieg_defs.svh ----
// Offsets, field positions, reset values and sizes of the host interrupt enable gating block.
// Assumes inclusion by bare name from the package and from every design module.
`ifndef HIEG_DEFS_SVH
`define HIEG_DEFS_SVH

// Register width and bus address and data widths
`define HIEG_REG_W          16
`define HIEG_ADDR_W         12
`define HIEG_DATA_W         32

// Printed register indices; byte address is four times the index
`define HIEG_IDX_STATUS     10'h0d4
`define HIEG_IDX_ENABLE     10'h0d6
`define HIEG_IDX_ISO_OR     10'h0d8

// Event bit positions, shared by status and enable
`define HIEG_BIT_MSOF       0
`define HIEG_BIT_SOF        1
`define HIEG_BIT_DMA        3
`define HIEG_BIT_OPREG      4
`define HIEG_BIT_SUSP       5
`define HIEG_BIT_CLKRDY     6
`define HIEG_BIT_PERIODIC   7
`define HIEG_BIT_ASYNC      8
`define HIEG_BIT_ISO        9
`define HIEG_BIT_OTG        10

// Positions that carry an event; reserved 15..11 and 2 are out
`define HIEG_EVENT_MASK     16'h07fb

// Reset values
`define HIEG_RST_ENABLE     16'h0000
`define HIEG_RST_ISO_OR     16'h0000
`define HIEG_RST_STATUS     16'h0000

// Isochronous descriptor count
`define HIEG_ISO_DESC_N     16

// AXI responses
`define HIEG_RESP_OKAY      2'b00
`define HIEG_RESP_SLVERR    2'b10

`endif

// ---- hw/hieg_pkg.sv ----
// Types shared by the host interrupt enable gating block and its bus slave.
// Assumes the constants header sits beside it.
`include "hieg_defs.svh"

package hieg_pkg;

	// Per-event pulses from the host controller core
	typedef struct packed {
		logic otg_latch;
		logic iso_and_hit;
		logic async_done;
		logic periodic_done;
		logic clock_stable;
		logic suspend_entry;
		logic op_reg_change;
		logic dma_done;
		logic frame_start;
		logic microframe_start;
	} hieg_event_type;

	// One register write taken from the bus
	typedef struct packed {
		logic                     valid;
		logic [`HIEG_ADDR_W-1:0]  addr;
		logic [`HIEG_DATA_W-1:0]  data;
		logic [3:0]               strb;
	} hieg_wreq_type;

	// One register read taken from the bus
	typedef struct packed {
		logic                     valid;
		logic [`HIEG_ADDR_W-1:0]  addr;
	} hieg_rreq_type;

	// Slave write channel state, one-hot
	typedef enum logic [1:0] {
		HIEG_WR_COLLECT = 2'b01,
		HIEG_WR_RESPOND = 2'b10
	} hieg_wr_state_type;

endpackage : hieg_pkg

// ---- hw/hieg_axil.sv ----
// AXI4-Lite slave front end: turns bus transfers into one-cycle register requests.
// Assumes the register owner decodes combinationally and answers in the request cycle.
`timescale 1ns/10ps
`include "hieg_defs.svh"

module hieg_axil
	import hieg_pkg::*;
(
	// Clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// Write address and data
	input  wire logic [`HIEG_ADDR_W-1:0] s_axil_awaddr,
	input  wire logic                    s_axil_awvalid,
	output      logic                    s_axil_awready,
	input  wire logic [`HIEG_DATA_W-1:0] s_axil_wdata,
	input  wire logic [3:0]              s_axil_wstrb,
	input  wire logic                    s_axil_wvalid,
	output      logic                    s_axil_wready,
	// Write response
	output      logic [1:0]              s_axil_bresp,
	output      logic                    s_axil_bvalid,
	input  wire logic                    s_axil_bready,
	// Read address and data
	input  wire logic [`HIEG_ADDR_W-1:0] s_axil_araddr,
	input  wire logic                    s_axil_arvalid,
	output      logic                    s_axil_arready,
	output      logic [`HIEG_DATA_W-1:0] s_axil_rdata,
	output      logic [1:0]              s_axil_rresp,
	output      logic                    s_axil_rvalid,
	input  wire logic                    s_axil_rready,
	// Register side
	output      hieg_wreq_type           wreq,
	input  wire logic                    wr_ok,
	output      hieg_rreq_type           rreq,
	input  wire logic [`HIEG_DATA_W-1:0] rd_data,
	input  wire logic                    rd_ok
);

	hieg_wr_state_type          wr_state;
	logic                       aw_held;
	logic                       w_held;
	logic [`HIEG_ADDR_W-1:0]    aw_addr;
	logic [`HIEG_DATA_W-1:0]    w_data;
	logic [3:0]                 w_strb;

	// Each half is taken once, in either order
	assign s_axil_awready = (wr_state == HIEG_WR_COLLECT) && !aw_held;
	assign s_axil_wready  = (wr_state == HIEG_WR_COLLECT) && !w_held;
	assign s_axil_arready = !s_axil_rvalid;

	// Request towards the registers once both halves are held
	assign wreq.valid = (wr_state == HIEG_WR_COLLECT) && aw_held && w_held;
	assign wreq.addr  = aw_addr;
	assign wreq.data  = w_data;
	assign wreq.strb  = w_strb;
	assign rreq.valid = s_axil_arvalid && s_axil_arready;
	assign rreq.addr  = s_axil_araddr;

	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state      <= HIEG_WR_COLLECT;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp  <= `HIEG_RESP_OKAY;
		end else begin
			unique case (wr_state)
				HIEG_WR_COLLECT: begin
					if (s_axil_awvalid && s_axil_awready) begin
						aw_held <= 1'b1;
						aw_addr <= s_axil_awaddr;
					end
					if (s_axil_wvalid && s_axil_wready) begin
						w_held <= 1'b1;
						w_data <= s_axil_wdata;
						w_strb <= s_axil_wstrb;
					end
					if (wreq.valid) begin
						aw_held       <= 1'b0;
						w_held        <= 1'b0;
						s_axil_bvalid <= 1'b1;
						s_axil_bresp  <= wr_ok ? `HIEG_RESP_OKAY : `HIEG_RESP_SLVERR;
						wr_state      <= HIEG_WR_RESPOND;
					end
				end
				HIEG_WR_RESPOND: begin
					if (s_axil_bready) begin
						s_axil_bvalid <= 1'b0;
						wr_state      <= HIEG_WR_COLLECT;
					end
				end
			endcase
		end
	end

	// Read data captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata  <= '0;
			s_axil_rresp  <= `HIEG_RESP_OKAY;
		end else if (rreq.valid) begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata  <= rd_data;
			s_axil_rresp  <= rd_ok ? `HIEG_RESP_OKAY : `HIEG_RESP_SLVERR;
		end else if (s_axil_rready) begin
			s_axil_rvalid <= 1'b0;
		end
	end

endmodule : hieg_axil

// ---- hw/hieg_top.sv ----
// Host controller interrupt enable gating: event status, enable register, iso OR mask, irq line.
// Assumes event inputs are one-cycle pulses synchronous to aclk, and an AXI4-Lite master.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`include "hieg_defs.svh"

module hieg_top
	import hieg_pkg::*;
#(
	parameter int ISO_DESC_N = `HIEG_ISO_DESC_N
)
(
	// Clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// AXI4-Lite write address and data
	input  wire logic [`HIEG_ADDR_W-1:0] s_axil_awaddr,
	input  wire logic                    s_axil_awvalid,
	output      logic                    s_axil_awready,
	input  wire logic [`HIEG_DATA_W-1:0] s_axil_wdata,
	input  wire logic [3:0]              s_axil_wstrb,
	input  wire logic                    s_axil_wvalid,
	output      logic                    s_axil_wready,
	// AXI4-Lite write response
	output      logic [1:0]              s_axil_bresp,
	output      logic                    s_axil_bvalid,
	input  wire logic                    s_axil_bready,
	// AXI4-Lite read
	input  wire logic [`HIEG_ADDR_W-1:0] s_axil_araddr,
	input  wire logic                    s_axil_arvalid,
	output      logic                    s_axil_arready,
	output      logic [`HIEG_DATA_W-1:0] s_axil_rdata,
	output      logic [1:0]              s_axil_rresp,
	output      logic                    s_axil_rvalid,
	input  wire logic                    s_axil_rready,
	// Host controller events
	input  wire hieg_event_type          events,
	input  wire logic [ISO_DESC_N-1:0]   iso_done_map,
	// Interrupt toward the processor
	output      logic                    irq
);

	// Elaboration check on the descriptor count
	if (ISO_DESC_N != `HIEG_REG_W) begin : g_bad_iso_n
		$error("hieg_top: ISO_DESC_N must equal the register width");
	end

	// Byte addresses derived from the printed indices
	localparam logic [`HIEG_ADDR_W-1:0] ADDR_STATUS = {`HIEG_IDX_STATUS, 2'b00};
	localparam logic [`HIEG_ADDR_W-1:0] ADDR_ENABLE = {`HIEG_IDX_ENABLE, 2'b00};
	localparam logic [`HIEG_ADDR_W-1:0] ADDR_ISO_OR = {`HIEG_IDX_ISO_OR, 2'b00};
	localparam logic [`HIEG_REG_W-1:0]  EVENT_MASK  = `HIEG_EVENT_MASK;
	localparam logic [`HIEG_REG_W-1:0]  RST_STATUS  = `HIEG_RST_STATUS;

	hieg_wreq_type              wreq;
	hieg_rreq_type              rreq;
	logic                       wr_ok;
	logic                       rd_ok;
	logic [`HIEG_DATA_W-1:0]    rd_data;
	logic [`HIEG_REG_W-1:0]     host_event_status;
	logic [`HIEG_REG_W-1:0]     host_event_irq_enable;
	logic [`HIEG_REG_W-1:0]     iso_done_or_mask;
	logic [`HIEG_REG_W-1:0]     next_irq_enable;
	logic [`HIEG_REG_W-1:0]     next_iso_or_mask;
	logic [`HIEG_REG_W-1:0]     event_vec;
	logic [`HIEG_REG_W-1:0]     status_clear;
	logic                       wr_enable;
	logic                       wr_iso_or;
	logic                       sw_op_change;
	logic                       iso_or_hit;

	// Bus slave front end
	hieg_axil u_axil (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.s_axil_awaddr  (s_axil_awaddr),
		.s_axil_awvalid (s_axil_awvalid),
		.s_axil_awready (s_axil_awready),
		.s_axil_wdata   (s_axil_wdata),
		.s_axil_wstrb   (s_axil_wstrb),
		.s_axil_wvalid  (s_axil_wvalid),
		.s_axil_wready  (s_axil_wready),
		.s_axil_bresp   (s_axil_bresp),
		.s_axil_bvalid  (s_axil_bvalid),
		.s_axil_bready  (s_axil_bready),
		.s_axil_araddr  (s_axil_araddr),
		.s_axil_arvalid (s_axil_arvalid),
		.s_axil_arready (s_axil_arready),
		.s_axil_rdata   (s_axil_rdata),
		.s_axil_rresp   (s_axil_rresp),
		.s_axil_rvalid  (s_axil_rvalid),
		.s_axil_rready  (s_axil_rready),
		.wreq           (wreq),
		.wr_ok          (wr_ok),
		.rreq           (rreq),
		.rd_data        (rd_data),
		.rd_ok          (rd_ok)
	);

	// Write decode; status is read-only, writes to it are ignored
	assign wr_enable = wreq.valid && (wreq.addr == ADDR_ENABLE);
	assign wr_iso_or = wreq.valid && (wreq.addr == ADDR_ISO_OR);
	assign wr_ok     = (wreq.addr == ADDR_ENABLE) || (wreq.addr == ADDR_ISO_OR)
		|| (wreq.addr == ADDR_STATUS);

	// Byte lanes 0 and 1 merge into the 16-bit registers
	always_comb begin
		next_irq_enable  = host_event_irq_enable;
		next_iso_or_mask = iso_done_or_mask;
		if (wreq.strb[0]) begin
			next_irq_enable[7:0]  = wreq.data[7:0];
			next_iso_or_mask[7:0] = wreq.data[7:0];
		end
		if (wreq.strb[1]) begin
			next_irq_enable[15:8]  = wreq.data[15:8];
			next_iso_or_mask[15:8] = wreq.data[15:8];
		end
	end

	// Enable register; reserved positions stored as written, the irq gate masks them with EVENT_MASK
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_event_irq_enable <= `HIEG_RST_ENABLE;
		end else if (wr_enable) begin
			host_event_irq_enable <= next_irq_enable;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iso_done_or_mask <= `HIEG_RST_ISO_OR;
		end else if (wr_iso_or) begin
			iso_done_or_mask <= next_iso_or_mask;
		end
	end

	assign iso_or_hit = |(iso_done_map & iso_done_or_mask);

	// software change of an operational register
	assign sw_op_change = (wr_enable && (next_irq_enable != host_event_irq_enable))
		|| (wr_iso_or && (next_iso_or_mask != iso_done_or_mask));

	always_comb begin
		event_vec                     = '0;
		event_vec[`HIEG_BIT_OTG]      = events.otg_latch;
		event_vec[`HIEG_BIT_ISO]      = iso_or_hit || events.iso_and_hit;
		event_vec[`HIEG_BIT_ASYNC]    = events.async_done;
		event_vec[`HIEG_BIT_PERIODIC] = events.periodic_done;
		event_vec[`HIEG_BIT_CLKRDY]   = events.clock_stable;
		event_vec[`HIEG_BIT_SUSP]     = events.suspend_entry;
		event_vec[`HIEG_BIT_OPREG]    = events.op_reg_change || sw_op_change;
		event_vec[`HIEG_BIT_DMA]      = events.dma_done;
		event_vec[`HIEG_BIT_SOF]      = events.frame_start;
		event_vec[`HIEG_BIT_MSOF]     = events.microframe_start;
	end

	// A status read clears exactly the bits it returned
	assign status_clear = (rreq.valid && (rreq.addr == ADDR_STATUS))
		? host_event_status : '0;

	// sticky flag per bit, set wins over read clear
	for (genvar i = 0; i < `HIEG_REG_W; i++) begin : g_status
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				host_event_status[i] <= RST_STATUS[i];
			end else if (event_vec[i] && EVENT_MASK[i]) begin
				host_event_status[i] <= 1'b1;
			end else if (status_clear[i]) begin
				host_event_status[i] <= 1'b0;
			end
		end
	end

	// Read mux; unmapped addresses answer SLVERR with zero data
	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		unique case (rreq.addr)
			ADDR_STATUS: rd_data[`HIEG_REG_W-1:0] = host_event_status;
			ADDR_ENABLE: rd_data[`HIEG_REG_W-1:0] = host_event_irq_enable;
			ADDR_ISO_OR: rd_data[`HIEG_REG_W-1:0] = iso_done_or_mask;
			default:     rd_ok = 1'b0;
		endcase
	end

	// gated OR of status and enable, reserved excluded
	assign irq = |(host_event_status & host_event_irq_enable & EVENT_MASK);

	// Assertions
	default clocking cb_main @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_otg_gate;
		events.otg_latch && host_event_irq_enable[`HIEG_BIT_OTG] && !wr_enable |=> irq;
	endproperty
	a_otg_gate: assert property (p_otg_gate)
		else $error("OTG event with enable set did not raise irq");

	property p_iso_gate;
		events.iso_and_hit && host_event_irq_enable[`HIEG_BIT_ISO] && !wr_enable |=> irq;
	endproperty
	a_iso_gate: assert property (p_iso_gate)
		else $error("Iso AND completion with enable set did not raise irq");

	property p_async_gate;
		events.async_done && host_event_irq_enable[`HIEG_BIT_ASYNC] && !wr_enable |=> irq;
	endproperty
	a_async_gate: assert property (p_async_gate)
		else $error("Async completion with enable set did not raise irq");

	property p_periodic_gate;
		events.periodic_done && host_event_irq_enable[`HIEG_BIT_PERIODIC] && !wr_enable
			|=> irq && host_event_status[`HIEG_BIT_PERIODIC];
	endproperty
	a_periodic_gate: assert property (p_periodic_gate)
		else $error("Periodic completion with enable set did not raise irq");

	property p_clock_gate;
		events.clock_stable && host_event_irq_enable[`HIEG_BIT_CLKRDY] && !wr_enable |=> irq;
	endproperty
	a_clock_gate: assert property (p_clock_gate)
		else $error("Clock-stable event with enable set did not raise irq");

	property p_suspend_gate;
		events.suspend_entry && host_event_irq_enable[`HIEG_BIT_SUSP] && !wr_enable |=> irq;
	endproperty
	a_suspend_gate: assert property (p_suspend_gate)
		else $error("Suspend entry with enable set did not raise irq");

	property p_opreg_sw;
		wr_iso_or && (next_iso_or_mask != iso_done_or_mask)
			|=> host_event_status[`HIEG_BIT_OPREG];
	endproperty
	a_opreg_sw: assert property (p_opreg_sw)
		else $error("Mask change by software did not flag an operational change");

	property p_dma_gate;
		events.dma_done && host_event_irq_enable[`HIEG_BIT_DMA] && !wr_enable |=> irq;
	endproperty
	a_dma_gate: assert property (p_dma_gate)
		else $error("DMA completion with enable set did not raise irq");

	property p_sof_gate;
		events.frame_start && host_event_irq_enable[`HIEG_BIT_SOF] && !wr_enable |=> irq;
	endproperty
	a_sof_gate: assert property (p_sof_gate)
		else $error("Frame start with enable set did not raise irq");

	property p_msof_gate;
		events.microframe_start && host_event_irq_enable[`HIEG_BIT_MSOF] && !wr_enable
			|=> irq;
	endproperty
	a_msof_gate: assert property (p_msof_gate)
		else $error("Micro-frame start with enable set did not raise irq");

	property p_iso_or_set;
		iso_or_hit |=> host_event_status[`HIEG_BIT_ISO];
	endproperty
	a_iso_or_set: assert property (p_iso_or_set)
		else $error("Masked iso completion did not set its status flag");

	property p_iso_or_excl;
		!host_event_status[`HIEG_BIT_ISO] && !iso_or_hit && !events.iso_and_hit
			|=> !host_event_status[`HIEG_BIT_ISO];
	endproperty
	a_iso_or_excl: assert property (p_iso_or_excl)
		else $error("Iso status rose with no masked completion");

	property p_enable_only;
		irq |-> (host_event_status & host_event_irq_enable) != '0;
	endproperty
	a_enable_only: assert property (p_enable_only)
		else $error("Irq high with no enabled status flag");

	property p_reserved_quiet;
		(host_event_status & ~EVENT_MASK) == '0;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet)
		else $error("Reserved status position became set");

	property p_masked_silent;
		host_event_irq_enable == '0 |-> !irq;
	endproperty
	a_masked_silent: assert property (p_masked_silent)
		else $error("Irq high while all enables are clear");

	property p_set_beats_clear;
		status_clear[`HIEG_BIT_SOF] && events.frame_start
			|=> host_event_status[`HIEG_BIT_SOF];
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear)
		else $error("Frame start lost while its flag was read-cleared");

	// Closed gates stay silent, reads clear, flags stick, enable writes land, registers hold
	property p_gate_closed;
		(host_event_status & host_event_irq_enable & EVENT_MASK) == '0
			&& (event_vec & host_event_irq_enable) == '0 && !wr_enable
			|=> !irq;
	endproperty
	a_gate_closed: assert property (p_gate_closed)
		else $error("Event with its enable bit clear raised irq");

	property p_read_clears;
		rreq.valid && (rreq.addr == ADDR_STATUS) && (event_vec & EVENT_MASK) == '0
			|=> host_event_status == '0;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("Status read left a flag set with no new event");

	property p_flag_sticky;
		!(rreq.valid && (rreq.addr == ADDR_STATUS))
			|=> (host_event_status & $past(host_event_status)) == $past(host_event_status);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("Status flag dropped without a status read");

	property p_enable_write;
		wr_enable |=> host_event_irq_enable == $past(next_irq_enable);
	endproperty
	a_enable_write: assert property (p_enable_write)
		else $error("Enable write did not land");

	property p_enable_hold;
		!wr_enable |=> $stable(host_event_irq_enable);
	endproperty
	a_enable_hold: assert property (p_enable_hold)
		else $error("Enable register changed without a write");

	property p_mask_hold;
		!wr_iso_or |=> $stable(iso_done_or_mask);
	endproperty
	a_mask_hold: assert property (p_mask_hold)
		else $error("Iso OR mask changed without a write");

endmodule : hieg_top

// ---- sim/hieg_irq_host.sv ----
// Processor-side model of the interrupt line: counts the assertions it would service.
// Assumes irq is a level synchronous to aclk.
`timescale 1ns/10ps

module hieg_irq_host (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Interrupt line and service count
	input  wire logic        irq,
	output      logic [15:0] irq_seen
);
	logic irq_last;

	// Count each rising edge of the level line once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_last <= 1'b0;
			irq_seen <= 16'h0000;
		end else begin
			irq_last <= irq;
			if (irq && !irq_last) begin
				irq_seen <= irq_seen + 16'h0001;
			end
		end
	end
endmodule : hieg_irq_host

// ---- sim/test_host_irq_enable_gating.sv ----
// Self-checking bench: AXI4-Lite register access, event pulses and irq gating.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/10ps
`include "hieg_defs.svh"

module test_host_irq_enable_gating;
	import hieg_pkg::*;
	localparam logic [11:0] A_ST  = {`HIEG_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_EN  = {`HIEG_IDX_ENABLE, 2'b00};
	localparam logic [11:0] A_ISO = {`HIEG_IDX_ISO_OR, 2'b00};
	logic                    aclk, aresetn;
	logic [11:0]             awaddr, araddr;
	logic                    awvalid, awready, wvalid, wready, bvalid, bready;
	logic                    arvalid, arready, rvalid, rready, irq;
	logic [31:0]             wdata, rdata, rd;
	logic [3:0]              wstrb;
	logic [1:0]              bresp, rresp, rsp;
	hieg_event_type          events;
	logic [15:0]             iso_done_map, irq_seen, seen0, en;
	int                      fail_count, checked, cycles;
	int                      pos [10] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10};

	hieg_top uut (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr),
		.s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
		.s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
		.s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
		.s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .events(events), .iso_done_map(iso_done_map), .irq(irq));

	hieg_irq_host host (.aclk(aclk), .aresetn(aresetn), .irq(irq), .irq_seen(irq_seen));

	// Clock at 50 MHz
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One write; address and data offered together, response awaited
	task automatic axi_write(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
		logic pa, pw, pb, ta, tw, tb;
		int   n;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		r = 2'b11;
		for (n = 0; pa || pw || pb; n++) begin
			@(negedge aclk);
			ta = pa && awready;
			tw = pw && wready;
			tb = pb && bvalid;
			if (tb) r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
			pb = pb && !tb;
		end
		if (n >= 100) check("write wait", 32'h1, 32'h0);
	endtask : axi_write

	// One read; data and response taken at the first falling aclk edge with rvalid high
	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic pa, pr, ta, tr;
		int   n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		pa = 1'b1;
		pr = 1'b1;
		for (n = 0; pa || pr; n++) begin
			@(negedge aclk);
			ta = pa && arready;
			tr = pr && rvalid && !pa;
			if (tr) {d, r} = {rdata, rresp};
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			pa = pa && !ta;
			pr = pr && !tr;
		end
		if (n >= 100) check("read wait", 32'h1, 32'h0);
	endtask : axi_read

	// One-cycle event and done-map pulse, then settle
	task automatic pulse(input hieg_event_type ev, input logic [15:0] map);
		@(posedge aclk);
		events <= ev;
		iso_done_map <= map;
		@(posedge aclk);
		events <= '0;
		iso_done_map <= 16'h0000;
		@(negedge aclk);
	endtask : pulse

	// Main sequence
	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hf;
		events = '0;
		iso_done_map = 16'h0000;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(A_EN, rd, rsp);
		check("enable reset", rd, 32'h0);
		axi_read(A_ISO, rd, rsp);
		check("iso mask reset", rd, 32'h0);
		axi_read(A_ST, rd, rsp);
		check("status reset", rd, 32'h0);
		check("irq reset", irq, 32'h0);
		axi_write(12'h004, 16'hffff, rsp);
		check("unmapped write resp", rsp, `HIEG_RESP_SLVERR);
		axi_read(12'h004, rd, rsp);
		check("unmapped read resp", rsp, `HIEG_RESP_SLVERR);
		// Each event enabled alone, then every other event enabled
		for (int k = 0; k < 10; k++) begin
			for (int on = 1; on >= 0; on--) begin
				en = on ? 16'h0001 << pos[k] : 16'h07fb & ~(16'h0001 << pos[k]);
				axi_write(A_EN, en, rsp);
				check("enable write resp", rsp, `HIEG_RESP_OKAY);
				axi_read(A_EN, rd, rsp);
				check("enable readback", rd, {16'h0000, en});
				axi_read(A_ST, rd, rsp);
				seen0 = irq_seen;
				pulse(hieg_event_type'(10'(1 << k)), 16'h0000);
				check("irq level", irq, 32'(on));
				@(negedge aclk);
				check("irq edges", irq_seen - seen0, 32'(on));
				axi_read(A_ST, rd, rsp);
				check("status flag", rd, 32'h1 << pos[k]);
			end
		end
		// Isochronous OR mask selects descriptors
		axi_write(A_ISO, 16'h8001, rsp);
		axi_read(A_ISO, rd, rsp);
		check("iso mask readback", rd, 32'h8001);
		axi_write(A_EN, 16'h0200, rsp);
		axi_read(A_ST, rd, rsp);
		pulse('0, 16'h7ffe);
		check("iso outside mask", irq, 32'h0);
		pulse('0, 16'h8000);
		check("iso inside mask", irq, 32'h1);
		axi_read(A_ST, rd, rsp);
		check("iso status", rd, 32'h0200);
		// Frame start in the cycle of a status read keeps its flag
		pulse(hieg_event_type'(10'h002), 16'h0000);
		fork
			axi_read(A_ST, rd, rsp);
			pulse(hieg_event_type'(10'h002), 16'h0000);
		join
		axi_read(A_ST, rd, rsp);
		check("set beats clear", rd, 32'h0002);
		// Software change of an operational register
		axi_write(A_EN, 16'h0010, rsp);
		axi_read(A_ST, rd, rsp);
		axi_write(A_ISO, 16'h0001, rsp);
		@(negedge aclk);
		check("op change irq", irq, 32'h1);
		axi_read(A_ST, rd, rsp);
		check("op change status", rd, 32'h0010);
		test_done();
	end
endmodule : test_host_irq_enable_gating
